/* design/serial_mode_regs.svh */
// Register offsets, field positions, reset values and timing counts for the serial mode block
`ifndef SERIAL_MODE_REGS_SVH
`define SERIAL_MODE_REGS_SVH
`define SMC_ADDR_MODE        4'h0
`define SMC_ADDR_DIVISOR     4'h1
`define SMC_ADDR_TXDATA      4'h2
`define SMC_ADDR_RXDATA      4'h3
`define SMC_ADDR_STATUS      4'h4
`define SMC_BIT_AUTORATE     5
`define SMC_BIT_RXINV        4
`define SMC_BIT_HISPEED      3
`define SMC_FMT_HI           2
`define SMC_FMT_LO           1
`define SMC_BIT_STOP         0
`define SMC_MODE_RESET       16'h0000
`define SMC_DIV_RESET        16'h000C
`define SMC_SYNC_CHAR        8'h55
`define SMC_SYNC_EDGES       4'h8
`define SMC_OSR_HI           5'h04
`define SMC_OSR_STD          5'h10
`endif

/* design/serial_mode_pkg.sv */
// Types shared by the serial mode block
package serial_mode_pkg;
	typedef enum logic [1:0] {
		FMT_8N = 2'b00,
		FMT_8E = 2'b01,
		FMT_8O = 2'b10,
		FMT_9N = 2'b11
	} frame_fmt_e;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_AUTO} rx_state_e;
endpackage

/* design/uart_frame_and_baud_config.sv */
// Serial port with mode register, baud generator, framing and automatic rate measurement
// How it works
// - Armed auto-rate times next character, not data
// - Hardware clears auto-rate enable after measuring
// - Invert set means low receive line is idle; transmit line still idles high
// - High-speed select gives four samples per bit
// - Standard select gives sixteen samples per bit
// - Format select picks 9N, 8O, 8E, 8N
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode_regs.svh"
module uart_frame_and_baud_config
	import serial_mode_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [15:0] rdata,
	// Serial line
	input  wire logic        serial_receive_line,
	output logic             serial_transmit_line
);
	function automatic logic par_of(input logic [8:0] d, input logic odd);
		par_of = ^d[7:0] ^ odd;
	endfunction

	logic [15:0] mode_reg, mode_next, div_reg, div_next, rdata_reg, rdata_next;
	logic [1:0]  rx_sync_reg;
	logic        rx_pin;
	logic [15:0] tick_cnt_reg, tick_cnt_next;
	logic        tick;
	logic [4:0]  osr;
	frame_fmt_e  fmt;
	logic        nine, par_en, par_odd, two_stop;
	// Transmit
	tx_state_e   tx_st_reg, tx_st_next;
	logic [8:0]  tx_sh_reg, tx_sh_next, tx_buf_reg, tx_buf_next;
	logic        tx_pend_reg, tx_pend_next, txo_reg, txo_next;
	logic [4:0]  tx_ph_reg, tx_ph_next;
	logic [3:0]  tx_bit_reg, tx_bit_next;
	// Receive
	rx_state_e   rx_st_reg, rx_st_next;
	logic [8:0]  rx_sh_reg, rx_sh_next, rx_data_reg, rx_data_next;
	logic [4:0]  rx_ph_reg, rx_ph_next;
	logic [3:0]  rx_bit_reg, rx_bit_next;
	logic        rx_full_reg, rx_full_next, perr_reg, perr_next, ferr_reg, ferr_next;
	logic        rx_prev_reg, rx_prev_next;
	logic [3:0]  edge_cnt_reg, edge_cnt_next;
	logic [19:0] meas_reg, meas_next;
	logic        rx_act;

	assign fmt      = frame_fmt_e'(mode_reg[`SMC_FMT_HI:`SMC_FMT_LO]);
	assign nine     = (fmt == FMT_9N);
	assign par_en   = (fmt == FMT_8E) || (fmt == FMT_8O);
	assign par_odd  = (fmt == FMT_8O);
	assign two_stop = mode_reg[`SMC_BIT_STOP];
	assign osr      = mode_reg[`SMC_BIT_HISPEED] ? `SMC_OSR_HI : `SMC_OSR_STD;
	// Active level seen as one when line is idle, whichever polarity
	assign rx_act   = rx_pin ^ mode_reg[`SMC_BIT_RXINV];
	assign rx_pin   = rx_sync_reg[1];
	assign tick     = (tick_cnt_reg == 16'h0000);

	always_comb begin
		tick_cnt_next = tick ? div_reg : tick_cnt_reg - 16'h0001;
	end

	// Transmit framing; divisor plus one mclk per sample tick
	always_comb begin
		tx_st_next   = tx_st_reg;
		tx_sh_next   = tx_sh_reg;
		tx_buf_next  = tx_buf_reg;
		tx_pend_next = tx_pend_reg;
		txo_next     = txo_reg;
		tx_ph_next   = tx_ph_reg;
		tx_bit_next  = tx_bit_reg;
		if (wr_stb && addr == `SMC_ADDR_TXDATA) begin
			tx_buf_next  = wdata[8:0];
			tx_pend_next = 1'b1;
		end
		if (tick) begin
			tx_ph_next = tx_ph_reg + 5'h01;
			unique case (tx_st_reg)
				TX_IDLE: begin
					txo_next   = 1'b1;
					tx_ph_next = 5'h00;
					if (tx_pend_reg) begin
						tx_sh_next   = tx_buf_reg;
						tx_pend_next = 1'b0;
						tx_st_next   = TX_START;
						txo_next     = 1'b0;
					end
				end
				TX_START: if (tx_ph_reg == osr - 5'h01) begin
					tx_ph_next  = 5'h00;
					tx_bit_next = 4'h0;
					txo_next    = tx_sh_reg[0];
					tx_st_next  = TX_DATA;
				end
				TX_DATA: if (tx_ph_reg == osr - 5'h01) begin
					tx_ph_next  = 5'h00;
					tx_bit_next = tx_bit_reg + 4'h1;
					if (tx_bit_reg == (nine ? 4'h8 : 4'h7)) begin
						if (par_en) begin
							txo_next   = par_of(tx_sh_reg, par_odd);
							tx_st_next = TX_PAR;
						end else begin
							txo_next    = 1'b1;
							tx_bit_next = 4'h0;
							tx_st_next  = TX_STOP;
						end
					end else begin
						txo_next = tx_sh_reg[tx_bit_reg + 4'h1];
					end
				end
				TX_PAR: if (tx_ph_reg == osr - 5'h01) begin
					tx_ph_next  = 5'h00;
					tx_bit_next = 4'h0;
					txo_next    = 1'b1;
					tx_st_next  = TX_STOP;
				end
				TX_STOP: if (tx_ph_reg == osr - 5'h01) begin
					tx_ph_next  = 5'h00;
					tx_bit_next = tx_bit_reg + 4'h1;
					if (!two_stop || tx_bit_reg == 4'h1)
						tx_st_next = TX_IDLE;
				end
			endcase
		end
	end

	// Receive framing and rate measurement
	always_comb begin
		rx_st_next    = rx_st_reg;
		rx_sh_next    = rx_sh_reg;
		rx_data_next  = rx_data_reg;
		rx_ph_next    = rx_ph_reg;
		rx_bit_next   = rx_bit_reg;
		rx_full_next  = rx_full_reg;
		perr_next     = perr_reg;
		ferr_next     = ferr_reg;
		rx_prev_next  = rx_act;
		edge_cnt_next = edge_cnt_reg;
		meas_next     = meas_reg;
		mode_next     = mode_reg;
		div_next      = div_reg;
		if (rd_stb && addr == `SMC_ADDR_RXDATA)
			rx_full_next = 1'b0;
		if (wr_stb && addr == `SMC_ADDR_STATUS) begin
			perr_next = perr_reg & ~wdata[1];
			ferr_next = ferr_reg & ~wdata[2];
		end
		if (wr_stb && addr == `SMC_ADDR_MODE)
			mode_next = wdata;
		if (wr_stb && addr == `SMC_ADDR_DIVISOR)
			div_next = wdata;
		unique case (rx_st_reg)
			RX_IDLE: begin
				rx_ph_next = 5'h00;
				if (rx_prev_reg && !rx_act) begin
					// Sync char 55h gives 8 falling/rising edges over 8 bit times
					if (mode_reg[`SMC_BIT_AUTORATE]) begin
						rx_st_next    = RX_AUTO;
						edge_cnt_next = 4'h0;
						// Starting at one makes the count equal the mclk span between edges
						meas_next     = 20'h00001;
					end else begin
						rx_st_next = RX_START;
					end
				end
			end
			RX_AUTO: begin
				meas_next = meas_reg + 20'h00001;
				if (rx_prev_reg != rx_act) begin
					edge_cnt_next = edge_cnt_reg + 4'h1;
					if (edge_cnt_reg == `SMC_SYNC_EDGES - 4'h1) begin
						// Eight bit times measured: divisor = T/(8*osr) - 1
						div_next = mode_reg[`SMC_BIT_HISPEED] ?
							{1'b0, meas_reg[19:5]} - 16'h0001 :
							{3'b000, meas_reg[19:7]} - 16'h0001;
						mode_next[`SMC_BIT_AUTORATE] = 1'b0;
						// Line stays low through bit 7, so idle sees no false start
						rx_st_next = RX_IDLE;
					end
				end
			end
			default: if (tick) begin
				rx_ph_next = rx_ph_reg + 5'h01;
				unique case (rx_st_reg)
					RX_START: if (rx_ph_reg == (osr >> 1)) begin
						rx_ph_next  = 5'h00;
						rx_bit_next = 4'h0;
						rx_st_next  = rx_act ? RX_IDLE : RX_DATA;
					end
					RX_DATA: if (rx_ph_reg == osr - 5'h01) begin
						rx_ph_next  = 5'h00;
						rx_sh_next  = {rx_act, rx_sh_reg[8:1]};
						rx_bit_next = rx_bit_reg + 4'h1;
						if (rx_bit_reg == (nine ? 4'h8 : 4'h7)) begin
							if (!nine)
								rx_sh_next = {1'b0, rx_act, rx_sh_reg[8:2]};
							rx_bit_next = 4'h0;
							rx_st_next  = par_en ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: if (rx_ph_reg == osr - 5'h01) begin
						rx_ph_next = 5'h00;
						if (rx_act != par_of(rx_sh_reg, par_odd))
							perr_next = 1'b1;
						rx_st_next = RX_STOP;
					end
					RX_STOP: if (rx_ph_reg == osr - 5'h01) begin
						rx_ph_next  = 5'h00;
						rx_bit_next = rx_bit_reg + 4'h1;
						if (!rx_act)
							ferr_next = 1'b1;
						if (!two_stop || rx_bit_reg == 4'h1) begin
							rx_st_next   = RX_IDLE;
							rx_data_next = rx_sh_reg;
							rx_full_next = 1'b1;
						end
					end
					default: rx_st_next = RX_IDLE;
				endcase
			end
		endcase
	end

	always_comb begin
		rdata_next = 16'h0000;
		if (rd_stb) begin
			unique case (addr)
				`SMC_ADDR_MODE:    rdata_next = mode_reg;
				`SMC_ADDR_DIVISOR: rdata_next = div_reg;
				`SMC_ADDR_RXDATA:  rdata_next = {7'h00, rx_data_reg};
				`SMC_ADDR_STATUS:  rdata_next = {11'h000, tx_pend_reg, tx_st_reg != TX_IDLE,
					ferr_reg, perr_reg, rx_full_reg};
				default:           rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync_reg  <= 2'b11;
			mode_reg     <= `SMC_MODE_RESET;
			div_reg      <= `SMC_DIV_RESET;
			rdata_reg    <= 16'h0000;
			tick_cnt_reg <= 16'h0000;
			tx_st_reg    <= TX_IDLE;
			tx_sh_reg    <= 9'h000;
			tx_buf_reg   <= 9'h000;
			tx_pend_reg  <= 1'b0;
			txo_reg      <= 1'b1;
			tx_ph_reg    <= 5'h00;
			tx_bit_reg   <= 4'h0;
			rx_st_reg    <= RX_IDLE;
			rx_sh_reg    <= 9'h000;
			rx_data_reg  <= 9'h000;
			rx_ph_reg    <= 5'h00;
			rx_bit_reg   <= 4'h0;
			rx_full_reg  <= 1'b0;
			perr_reg     <= 1'b0;
			ferr_reg     <= 1'b0;
			rx_prev_reg  <= 1'b1;
			edge_cnt_reg <= 4'h0;
			meas_reg     <= 20'h00000;
		end else begin
			rx_sync_reg  <= {rx_sync_reg[0], serial_receive_line};
			mode_reg     <= mode_next;
			div_reg      <= div_next;
			rdata_reg    <= rdata_next;
			tick_cnt_reg <= tick_cnt_next;
			tx_st_reg    <= tx_st_next;
			tx_sh_reg    <= tx_sh_next;
			tx_buf_reg   <= tx_buf_next;
			tx_pend_reg  <= tx_pend_next;
			txo_reg      <= txo_next;
			tx_ph_reg    <= tx_ph_next;
			tx_bit_reg   <= tx_bit_next;
			rx_st_reg    <= rx_st_next;
			rx_sh_reg    <= rx_sh_next;
			rx_data_reg  <= rx_data_next;
			rx_ph_reg    <= rx_ph_next;
			rx_bit_reg   <= rx_bit_next;
			rx_full_reg  <= rx_full_next;
			perr_reg     <= perr_next;
			ferr_reg     <= ferr_next;
			rx_prev_reg  <= rx_prev_next;
			edge_cnt_reg <= edge_cnt_next;
			meas_reg     <= meas_next;
		end
	end

	assign rdata                = rdata_reg;
	assign serial_transmit_line = txo_reg;
endmodule
`default_nettype wire

/* tb/uart_frame_and_baud_config_sva.sv */
// Port checks for the serial mode block
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode_regs.svh"
module uart_frame_and_baud_config_sva (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// Register port
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [15:0] rdata,
	// Serial line
	input wire logic        serial_receive_line,
	input wire logic        serial_transmit_line
);
	logic [5:0]  mode_m;
	logic [15:0] div_m;
	logic        div_ok, tx_q, in_fr, tx_used;
	int          cnt, bt, fl, nst;
	// Frame timing is only trusted while the divisor mirror matches software
	assign bt = (int'(div_m) + 1) * (mode_m[3] ? 4 : 16);
	assign nst = mode_m[0] ? 2 : 1;
	assign fl = 9 + int'(mode_m[2:1] != 2'b00) + nst;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_m <= 6'h00;
			div_m <= `SMC_DIV_RESET;
			div_ok <= 1'b1;
			tx_q <= 1'b1;
			in_fr <= 1'b0;
			tx_used <= 1'b0;
			cnt <= 0;
		end else begin
			if (wr_stb && addr == `SMC_ADDR_MODE) mode_m <= wdata[5:0];
			if (wr_stb && addr == `SMC_ADDR_DIVISOR) div_m <= wdata;
			if (wr_stb && addr == `SMC_ADDR_DIVISOR) div_ok <= 1'b1;
			else if (wr_stb && addr == `SMC_ADDR_MODE && wdata[5]) div_ok <= 1'b0;
			if (wr_stb && addr == `SMC_ADDR_TXDATA) tx_used <= 1'b1;
			tx_q <= serial_transmit_line;
			if (tx_q && !serial_transmit_line && (!in_fr || cnt == fl * bt)) begin
				in_fr <= 1'b1;
				cnt <= 1;
			end else if (cnt == fl * bt) in_fr <= 1'b0;
			else cnt <= cnt + 1;
		end
	end
	sequence s_rd(logic [3:0] a);
		rd_stb && addr == a;
	endsequence
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_rdata_idle_zero:
	assert property (!$past(rd_stb) |-> rdata == 16'h0000) else $error("read data not idle");
	a_mode_read_back:
	assert property (s_rd(4'h0) |=> rdata[4:0] == $past(mode_m[4:0]))
		else $error("mode fields read back wrong");
	a_auto_no_self_set:
	assert property (s_rd(4'h0) and !mode_m[5] |=> !rdata[5]) else $error("auto rate set alone");
	a_div_read_back:
	assert property (s_rd(4'h1) and div_ok |=> rdata == $past(div_m))
		else $error("divisor read back wrong");
	a_unmapped_zero:
	assert property (rd_stb && addr > 4'h4 |=> rdata == 16'h0000) else $error("unmapped read");
	a_bit_edge_grid:
	assert property (div_ok && in_fr && serial_transmit_line != tx_q |-> cnt % bt == 0)
		else $error("transmit edge off bit grid");
	a_stop_bits_high:
	assert property (div_ok && in_fr && cnt >= (fl - nst) * bt && cnt < fl * bt
		|-> serial_transmit_line) else $error("stop bit low");
	a_tx_idle_unused:
	assert property (!tx_used |-> serial_transmit_line) else $error("transmit left idle");
endmodule
bind uart_frame_and_baud_config uart_frame_and_baud_config_sva i_sva (
	.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rdata(rdata), .serial_receive_line(serial_receive_line),
	.serial_transmit_line(serial_transmit_line));
`default_nettype wire

/* tb/serial_remote.sv */
// Remote serial partner: drives the receive line and captures transmitted frames
`timescale 1ns/1ps
`default_nettype none
module serial_remote (
	// Clock
	input  wire logic mclk,
	// Line
	input  wire logic tx,
	output var  logic line
);
	initial line = 1'b1;
	task automatic idle(input logic inv);
		@(posedge mclk) line <= ~inv;
	endtask
	task automatic send(input logic [12:0] b, input int n, input int bc, input logic inv);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) line <= b[i] ^ inv;
			repeat (bc - 1) @(posedge mclk);
		end
		@(posedge mclk) line <= ~inv;
	endtask
	// Returns at mid last stop so a back-to-back start is not missed
	task automatic catch(output logic [12:0] b, output time t, input int n, input int bc);
		b = '1;
		@(negedge tx);
		t = $time;
		repeat (bc / 2) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			b[i] = tx;
			if (i < n - 1) repeat (bc) @(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire

/* tb/uart_frame_and_baud_config_test.sv */
// Self-checking bench for the serial mode block
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode_regs.svh"
module uart_frame_and_baud_config_test;
	localparam logic [3:0] r_mode = `SMC_ADDR_MODE;
	localparam logic [3:0] r_div = `SMC_ADDR_DIVISOR;
	localparam logic [3:0] r_tx = `SMC_ADDR_TXDATA;
	localparam logic [3:0] r_rx = `SMC_ADDR_RXDATA;
	localparam logic [3:0] r_st = `SMC_ADDR_STATUS;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	wire logic [15:0] rdata;
	wire logic   rx, tx;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	always #20 mclk = ~mclk;
	uart_frame_and_baud_config i_dut (
		.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .serial_receive_line(rx), .serial_transmit_line(tx));
	serial_remote i_rem (.mclk(mclk), .tx(tx), .line(rx));
	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] e,
		input logic [15:0] m);
		logic [15:0] v;
		rd(a, v);
		chk(nm, v & m, e);
	endtask
	// A polarity change glitches the line, so flush whatever it produced
	task automatic settle(input logic inv, input logic [15:0] m, input int bc);
		logic [15:0] v;
		i_rem.idle(inv);
		wr(r_mode, m);
		repeat (30 * bc) @(posedge mclk);
		rd(r_rx, v);
		wr(r_st, 16'h0006);
	endtask
	function automatic logic [12:0] fr(input logic [8:0] d, input logic [1:0] f,
		input logic s, output int n);
		fr = 13'h1FFF;
		fr[0] = 1'b0;
		fr[8:1] = d[7:0];
		n = (f == 2'b00) ? 10 : 11;
		if (f == 2'b11) fr[9] = d[8];
		else if (f != 2'b00) fr[9] = ^d[7:0] ^ f[1];
		n = n + int'(s);
	endfunction
	initial begin
		logic [12:0] b, e;
		logic [8:0]  d;
		time         t0, t1;
		int          n, bc;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rc("mode reset", r_mode, `SMC_MODE_RESET, 16'hFFFF);
		rc("div reset", r_div, `SMC_DIV_RESET, 16'hFFFF);
		wr(4'hF, 16'hFFFF);
		rc("unmapped", 4'hF, 16'h0000, 16'hFFFF);
		wr(r_div, 16'h0001);
		for (int k = 0; k < 16; k++) begin
			bc = 2 * (k[3] ? 4 : 16);
			d = 9'h0A5 + 9'(k * 23);
			wr(r_mode, 16'(k));
			e = fr(d, k[2:1], k[0], n);
			fork
				begin
					i_rem.catch(b, t0, n, bc);
					i_rem.catch(b, t1, n, bc);
				end
				begin
					wr(r_tx, 16'(d));
					repeat (4) @(posedge mclk);
					wr(r_tx, 16'(d));
				end
			join
			chk("tx frame", 16'(b), 16'(e));
			// One idle sample tick (divisor 1, two mclk) sits between queued frames
			chk("tx spacing", 16'((t1 - t0) / 40), 16'(n * bc + 2));
			repeat (bc) @(posedge mclk);
		end
		for (int k = 0; k < 4; k++) begin
			bc = 2 * (k[1] ? 4 : 16);
			d = 9'h13C + 9'(k * 41);
			settle(k[0], 16'({k[0], k[1], k[1:0], &k[1:0]}), bc);
			repeat (20 * bc) @(posedge mclk);
			rc("rx idle", r_st, 16'h0000, 16'h0007);
			e = fr(d, 2'(k), &k[1:0], n);
			if (k == 2) e[9] = ~e[9];
			// Low stop bit must still store the character but flag framing
			if (k == 1) e[n - 1] = ~e[n - 1];
			i_rem.send(e, n, bc, k[0]);
			repeat (2 * bc) @(posedge mclk);
			rc("rx status", r_st, (k == 2) ? 16'h0003 : (k == 1) ? 16'h0005 : 16'h0001,
				16'h0007);
			rc("rx data", r_rx, 16'(d) & ((k == 3) ? 16'h01FF : 16'h00FF), 16'h01FF);
		end
		settle(1'b0, 16'h0000, 32);
		wr(r_mode, 16'h0020);
		rc("armed", r_mode, 16'h0020, 16'h003F);
		e = fr(`SMC_SYNC_CHAR, 2'b00, 1'b0, n);
		i_rem.send(e, n, 96, 1'b0);
		repeat (192) @(posedge mclk);
		rc("auto clear", r_mode, 16'h0000, 16'h003F);
		rc("auto div", r_div, 16'h0005, 16'hFFFF);
		rc("sync not data", r_st, 16'h0000, 16'h0001);
		e = fr(9'h0C3, 2'b00, 1'b0, n);
		i_rem.send(e, n, 96, 1'b0);
		repeat (192) @(posedge mclk);
		rc("after auto", r_rx, 16'h00C3, 16'h01FF);
		give_verdict();
	end
endmodule
`default_nettype wire
